// File: core/cbap_map.svh
`ifndef CBAP_MAP_SVH
`define CBAP_MAP_SVH

// ****************************************
// bus geometry
// ****************************************
`define CBAP_ADDR_HI 31
`define CBAP_ADDR_LO 3
`define CBAP_INQ_LO 5
`define CBAP_A20_BIT 20
`define CBAP_BE_W 8
`define CBAP_BE_IO_W 5
`define CBAP_RATIO_W 3
`define CBAP_MULT_W 4

// ****************************************
// reset values
// ****************************************
`define CBAP_RST_ADDR 29'h0
`define CBAP_RST_BE 8'h00
`define CBAP_RST_RATIO 3'h0

// ****************************************
// timing counts
// ****************************************
`define CBAP_PERR_DELAY 2
`define CBAP_HOST_WAIT 2

`endif

// File: core/cbap_pkg.sv
`default_nettype none
`include "cbap_map.svh"

package cbap_pkg;

	typedef logic [`CBAP_ADDR_HI:`CBAP_ADDR_LO] cbap_addr_type;
	typedef logic [`CBAP_BE_W-1:0] cbap_be_type;
	typedef logic [`CBAP_RATIO_W-1:0] cbap_ratio_type;

	typedef enum logic [4:0]
	{
		CBAP_DEV_IDLE = 5'h01,
		CBAP_DEV_PEND = 5'h02,
		CBAP_DEV_ADDR = 5'h04,
		CBAP_DEV_WAIT = 5'h08,
		CBAP_DEV_HOLD = 5'h10
	} cbap_dev_state_type;

	typedef enum logic [2:0]
	{
		CBAP_HOST_IDLE = 3'h1,
		CBAP_HOST_BUSY = 3'h2,
		CBAP_HOST_DONE = 3'h4
	} cbap_host_state_type;

	// one bit that makes the ones count of the address even
	function automatic logic cbap_even_parity(input cbap_addr_type a);
		cbap_even_parity = ^a;
	endfunction

endpackage
`default_nettype wire

// File: core/cbap_bus_if.sv
`timescale 1ns/1ps
`default_nettype none
`include "cbap_map.svh"

interface cbap_bus_if;
	import cbap_pkg::*;

	// ****************************************
	// device-driven
	// ****************************************
	cbap_addr_type dev_addr_out;
	logic dev_addr_oe;
	logic dev_ap_out;
	logic dev_ap_oe;
	cbap_be_type byte_lane_enable_n_out;
	logic be_oe;
	logic cycle_addr_strobe_n_out;
	logic ads_oe;
	logic addr_parity_error_n;

	// ****************************************
	// host-driven
	// ****************************************
	cbap_addr_type host_addr_out;
	logic host_addr_oe;
	logic host_ap_out;
	logic host_ap_oe;
	logic addr_bit20_mask_n;
	logic addr_float_request;
	logic bus_abort_retry_n;
	logic inquire_addr_strobe_n;
	logic bus_cycle_done_n;
	cbap_ratio_type bus_core_ratio_sel;

	// ****************************************
	// resolved wires, undriven lines pull high
	// ****************************************
	cbap_addr_type addr;
	logic addr_even_parity;
	cbap_be_type byte_lane_enable_n;
	logic cycle_addr_strobe_n;

	assign addr = dev_addr_oe ? dev_addr_out :
		(host_addr_oe ? host_addr_out : '1);
	assign addr_even_parity = dev_ap_oe ? dev_ap_out :
		(host_ap_oe ? host_ap_out : 1'b1);
	assign byte_lane_enable_n = be_oe ? byte_lane_enable_n_out : '1;
	assign cycle_addr_strobe_n = ads_oe ? cycle_addr_strobe_n_out : 1'b1;

	modport dev
	(
		output dev_addr_out, dev_addr_oe, dev_ap_out, dev_ap_oe,
		output byte_lane_enable_n_out, be_oe,
		output cycle_addr_strobe_n_out, ads_oe, addr_parity_error_n,
		input addr, addr_even_parity,
		input addr_bit20_mask_n, addr_float_request, bus_abort_retry_n,
		input inquire_addr_strobe_n, bus_cycle_done_n, bus_core_ratio_sel
	);

	modport host
	(
		output host_addr_out, host_addr_oe, host_ap_out, host_ap_oe,
		output addr_bit20_mask_n, addr_float_request, bus_abort_retry_n,
		output inquire_addr_strobe_n, bus_cycle_done_n, bus_core_ratio_sel,
		input addr, addr_even_parity, byte_lane_enable_n,
		input cycle_addr_strobe_n, addr_parity_error_n
	);

endinterface
`default_nettype wire

// File: core/cbap_dev.sv
`timescale 1ns/1ps
`default_nettype none
`include "cbap_map.svh"

// Overview of operation
// - mask address bit 20 while mask asserted
// - system masks bit 20 only in real mode
// - device drives address and byte enables
// - strobe low marks a new bus cycle
// - address hold floats address, parity next clock
// - even address parity driven with address
// - system drives even parity with inquire strobe
// - parity error low two clocks, one clock
// - byte enables driven with address lines
// - ratio select sampled on first enabled clock after reset, then fixed
// - system holds ratio select steady in reset
// - backoff aborts cycles, floats bus next clock
// - hold until backoff negates, then reissue whole
// - trailing _n names are active low
module cbap_dev
	import cbap_pkg::*;
#(
	parameter int PERR_DELAY = `CBAP_PERR_DELAY
)
(
	input wire logic I_CORE_CLK,
	input wire logic I_RESET_N,
	input wire logic I_CLK_EN,
	cbap_bus_if.dev bus,
	input wire logic I_REQ_VALID,
	input wire cbap_addr_type I_REQ_ADDR,
	input wire cbap_be_type I_REQ_BYTE_EN,
	output logic O_REQ_READY,
	output logic O_CYCLE_DONE,
	output logic O_INQ_VALID,
	output logic [`CBAP_ADDR_HI:`CBAP_INQ_LO] O_INQ_ADDR,
	output logic O_INQ_PERR,
	output logic O_RATIO_VALID,
	output cbap_ratio_type O_RATIO_SEL,
	output logic [`CBAP_MULT_W-1:0] O_CORE_MULT
);

	// ****************************************
	// helpers
	// ****************************************
	// table is local to this core; retune with the clock plan
	function automatic logic [`CBAP_MULT_W-1:0] ratio_decode(
		input cbap_ratio_type sel);
		case (sel)
			3'h0: ratio_decode = 4'h2;
			3'h1: ratio_decode = 4'h3;
			3'h2: ratio_decode = 4'h4;
			3'h3: ratio_decode = 4'h5;
			3'h4: ratio_decode = 4'h6;
			3'h5: ratio_decode = 4'h7;
			3'h6: ratio_decode = 4'h8;
			default: ratio_decode = 4'h2;
		endcase
	endfunction

	cbap_dev_state_type state_reg;
	cbap_dev_state_type state_next;
	cbap_addr_type cur_addr_reg;
	cbap_be_type cur_be_reg;
	logic ready_reg, done_reg;
	logic ads_n_reg, ads_oe_reg, addr_oe_reg, be_oe_reg, ap_reg;
	logic [PERR_DELAY-1:0] perr_pipe_reg;
	logic addr_parity_error_n_n_reg;
	logic inq_valid_reg;
	logic [`CBAP_ADDR_HI:`CBAP_INQ_LO] inq_addr_reg;
	logic inq_perr_reg;
	logic ratio_valid_reg;
	cbap_ratio_type ratio_reg;
	logic [`CBAP_MULT_W-1:0] mult_reg;
	cbap_addr_type masked_addr;
	logic accept, backoff, inq_hit, inq_bad;

	assign backoff = ~bus.bus_abort_retry_n;
	assign accept = I_REQ_VALID & ready_reg & (state_reg == CBAP_DEV_IDLE);
	assign inq_hit = bus.addr_float_request & ~bus.inquire_addr_strobe_n;
	assign inq_bad = ^{bus.addr, bus.addr_even_parity};

	// ****************************************
	// address masking
	// ****************************************
	always_comb
	begin
		masked_addr = I_REQ_ADDR;
		if (!bus.addr_bit20_mask_n)
			masked_addr[`CBAP_A20_BIT] = 1'b0;
	end

	// ****************************************
	// cycle sequencer
	// ****************************************
	always_comb
	begin
		state_next = state_reg;
		case (state_reg)
			CBAP_DEV_IDLE:
				if (accept)
					state_next = CBAP_DEV_PEND;
			CBAP_DEV_PEND:
				if (backoff)
					state_next = CBAP_DEV_HOLD;
				else if (!bus.addr_float_request)
					state_next = CBAP_DEV_ADDR;
			CBAP_DEV_ADDR:
				if (backoff)
					state_next = CBAP_DEV_HOLD;
				else
					state_next = CBAP_DEV_WAIT;
			CBAP_DEV_WAIT:
				if (backoff)
					state_next = CBAP_DEV_HOLD;
				else if (!bus.bus_cycle_done_n)
					state_next = CBAP_DEV_IDLE;
			// restart from the address phase, never mid-cycle
			CBAP_DEV_HOLD:
				if (!backoff)
					state_next = CBAP_DEV_PEND;
			default: state_next = CBAP_DEV_IDLE;
		endcase
	end

	always_ff @(posedge I_CORE_CLK or negedge I_RESET_N)
	begin
		if (!I_RESET_N)
			state_reg <= CBAP_DEV_IDLE;
		else if (I_CLK_EN)
			state_reg <= state_next;
	end

	always_ff @(posedge I_CORE_CLK or negedge I_RESET_N)
	begin
		if (!I_RESET_N)
		begin
			cur_addr_reg <= `CBAP_RST_ADDR;
			cur_be_reg <= `CBAP_RST_BE;
		end
		else if (I_CLK_EN && accept)
		begin
			cur_addr_reg <= masked_addr;
			cur_be_reg <= ~I_REQ_BYTE_EN;
		end
	end

	always_ff @(posedge I_CORE_CLK or negedge I_RESET_N)
	begin
		if (!I_RESET_N)
		begin
			ready_reg <= 1'b0;
			done_reg <= 1'b0;
		end
		else if (I_CLK_EN)
		begin
			ready_reg <= (state_next == CBAP_DEV_IDLE) & ~accept;
			done_reg <= (state_reg == CBAP_DEV_WAIT) & ~backoff &
				~bus.bus_cycle_done_n;
		end
	end

	// ****************************************
	// pin drive
	// ****************************************
	always_ff @(posedge I_CORE_CLK or negedge I_RESET_N)
	begin
		if (!I_RESET_N)
		begin
			ads_n_reg <= 1'b1;
			ads_oe_reg <= 1'b0;
			addr_oe_reg <= 1'b0;
			be_oe_reg <= 1'b0;
			ap_reg <= 1'b0;
		end
		else if (I_CLK_EN)
		begin
			ads_n_reg <= ~(state_next == CBAP_DEV_ADDR);
			ads_oe_reg <= ~backoff;
			be_oe_reg <= ~backoff;
			// only address and parity let go under address hold
			addr_oe_reg <= ~backoff & ~bus.addr_float_request;
			ap_reg <= cbap_even_parity(cur_addr_reg);
			if (accept)
				ap_reg <= cbap_even_parity(masked_addr);
		end
	end

	assign bus.dev_addr_out = cur_addr_reg;
	assign bus.dev_addr_oe = addr_oe_reg;
	assign bus.dev_ap_out = ap_reg;
	assign bus.dev_ap_oe = addr_oe_reg;
	assign bus.byte_lane_enable_n_out = cur_be_reg;
	assign bus.be_oe = be_oe_reg;
	assign bus.cycle_addr_strobe_n_out = ads_n_reg;
	assign bus.ads_oe = ads_oe_reg;
	assign bus.addr_parity_error_n = addr_parity_error_n_n_reg;

	// ****************************************
	// inquire parity check
	// ****************************************
	always_ff @(posedge I_CORE_CLK or negedge I_RESET_N)
	begin
		if (!I_RESET_N)
		begin
			perr_pipe_reg <= '0;
			addr_parity_error_n_n_reg <= 1'b1;
		end
		else if (I_CLK_EN)
		begin
			// shift left; the cast drops the bit that falls off the top
			perr_pipe_reg <=
				PERR_DELAY'({perr_pipe_reg, inq_hit & inq_bad});
			// one low clock per error; back-to-back errors stay low
			addr_parity_error_n_n_reg <= ~perr_pipe_reg[PERR_DELAY-1];
		end
	end

	always_ff @(posedge I_CORE_CLK or negedge I_RESET_N)
	begin
		if (!I_RESET_N)
		begin
			inq_valid_reg <= 1'b0;
			inq_addr_reg <= '0;
			inq_perr_reg <= 1'b0;
		end
		else if (I_CLK_EN)
		begin
			inq_valid_reg <= inq_hit;
			inq_perr_reg <= inq_hit & inq_bad;
			if (inq_hit)
				inq_addr_reg <= bus.addr[`CBAP_ADDR_HI:`CBAP_INQ_LO];
		end
	end

	// ****************************************
	// ratio strap
	// ****************************************
	// caught on the first enabled edge after release; every reset re-arms
	always_ff @(posedge I_CORE_CLK or negedge I_RESET_N)
	begin
		if (!I_RESET_N)
		begin
			ratio_valid_reg <= 1'b0;
			ratio_reg <= `CBAP_RST_RATIO;
			mult_reg <= '0;
		end
		else if (I_CLK_EN && !ratio_valid_reg)
		begin
			ratio_valid_reg <= 1'b1;
			ratio_reg <= bus.bus_core_ratio_sel;
			mult_reg <= ratio_decode(bus.bus_core_ratio_sel);
		end
	end

	assign O_REQ_READY = ready_reg;
	assign O_CYCLE_DONE = done_reg;
	assign O_INQ_VALID = inq_valid_reg;
	assign O_INQ_ADDR = inq_addr_reg;
	assign O_INQ_PERR = inq_perr_reg;
	assign O_RATIO_VALID = ratio_valid_reg;
	assign O_RATIO_SEL = ratio_reg;
	assign O_CORE_MULT = mult_reg;

endmodule
`default_nettype wire

// File: core/cbap_host.sv
`timescale 1ns/1ps
`default_nettype none
`include "cbap_map.svh"

module cbap_host
	import cbap_pkg::*;
#(
	parameter int WAIT_CYC = `CBAP_HOST_WAIT,
	parameter cbap_ratio_type RATIO_STRAP = `CBAP_RST_RATIO
)
(
	input wire logic I_CORE_CLK,
	input wire logic I_RESET_N,
	input wire logic I_CLK_EN,
	cbap_bus_if.host bus,
	input wire logic I_A20_MASK,
	input wire logic I_ADDR_HOLD,
	input wire logic I_BACKOFF,
	input wire logic I_INQ_REQ,
	input wire logic [`CBAP_ADDR_HI:`CBAP_INQ_LO] I_INQ_ADDR,
	input wire logic I_INQ_BAD_PARITY,
	output logic O_INQ_READY,
	output logic O_CYCLE_SEEN,
	output cbap_addr_type O_CYCLE_ADDR,
	output cbap_be_type O_CYCLE_BE_N,
	output logic O_CYCLE_PERR,
	output logic O_INQ_ERR
);

	// ****************************************
	// control pins
	// ****************************************
	logic addr_bit20_mask_n_n_reg;
	logic addr_float_request_reg;
	logic addr_float_request_d_reg;
	logic bus_abort_retry_n_n_reg;
	logic inquire_addr_strobe_n_n_reg;
	logic haddr_oe_reg;
	cbap_addr_type haddr_reg;
	logic hap_reg;
	logic inq_ready_reg;
	logic inq_go;

	// caller keeps the mask for real-mode phases only
	always_ff @(posedge I_CORE_CLK or negedge I_RESET_N)
	begin
		if (!I_RESET_N)
		begin
			addr_bit20_mask_n_n_reg <= 1'b1;
			addr_float_request_reg <= 1'b0;
			addr_float_request_d_reg <= 1'b0;
			bus_abort_retry_n_n_reg <= 1'b1;
		end
		else if (I_CLK_EN)
		begin
			addr_bit20_mask_n_n_reg <= ~I_A20_MASK;
			addr_float_request_reg <= I_ADDR_HOLD;
			addr_float_request_d_reg <= addr_float_request_reg;
			bus_abort_retry_n_n_reg <= ~I_BACKOFF;
		end
	end

	// ****************************************
	// inquire drive
	// ****************************************
	// waits one clock of hold so the device has let go of the lines
	assign inq_go = I_INQ_REQ & inq_ready_reg & addr_float_request_reg & addr_float_request_d_reg;

	always_ff @(posedge I_CORE_CLK or negedge I_RESET_N)
	begin
		if (!I_RESET_N)
		begin
			inquire_addr_strobe_n_n_reg <= 1'b1;
			haddr_oe_reg <= 1'b0;
			haddr_reg <= `CBAP_RST_ADDR;
			hap_reg <= 1'b0;
			inq_ready_reg <= 1'b0;
		end
		else if (I_CLK_EN)
		begin
			inquire_addr_strobe_n_n_reg <= ~inq_go;
			haddr_oe_reg <= inq_go;
			inq_ready_reg <= addr_float_request_reg & addr_float_request_d_reg & I_ADDR_HOLD & ~inq_go;
			if (inq_go)
			begin
				haddr_reg <= {I_INQ_ADDR, 2'h0};
				hap_reg <= cbap_even_parity({I_INQ_ADDR, 2'h0}) ^
					I_INQ_BAD_PARITY;
			end
		end
	end

	assign bus.addr_bit20_mask_n = addr_bit20_mask_n_n_reg;
	assign bus.addr_float_request = addr_float_request_reg;
	assign bus.bus_abort_retry_n = bus_abort_retry_n_n_reg;
	assign bus.inquire_addr_strobe_n = inquire_addr_strobe_n_n_reg;
	assign bus.host_addr_out = haddr_reg;
	assign bus.host_addr_oe = haddr_oe_reg;
	assign bus.host_ap_out = hap_reg;
	assign bus.host_ap_oe = haddr_oe_reg;
	assign bus.bus_core_ratio_sel = RATIO_STRAP;

	// ****************************************
	// cycle acceptor
	// ****************************************
	cbap_host_state_type st_reg;
	logic [7:0] wait_reg;
	logic done_n_reg;
	logic seen_reg;
	cbap_addr_type seen_addr_reg;
	cbap_be_type seen_be_reg;
	logic seen_perr_reg;
	logic inq_err_reg;
	logic strobe;

	assign strobe = ~bus.cycle_addr_strobe_n;

	always_ff @(posedge I_CORE_CLK or negedge I_RESET_N)
	begin
		if (!I_RESET_N)
		begin
			st_reg <= CBAP_HOST_IDLE;
			wait_reg <= 8'h00;
			done_n_reg <= 1'b1;
		end
		else if (I_CLK_EN)
		begin
			done_n_reg <= 1'b1;
			case (st_reg)
				CBAP_HOST_IDLE:
				begin
					if (strobe)
					begin
						st_reg <= CBAP_HOST_BUSY;
						wait_reg <= 8'(WAIT_CYC);
					end
				end
				CBAP_HOST_BUSY:
				begin
					if (I_BACKOFF)
					begin
						st_reg <= CBAP_HOST_IDLE;
					end
					else if (wait_reg <= 8'h01)
					begin
						st_reg <= CBAP_HOST_DONE;
						done_n_reg <= 1'b0;
					end
					else
					begin
						wait_reg <= wait_reg - 8'h01;
					end
				end
				CBAP_HOST_DONE: st_reg <= CBAP_HOST_IDLE;
				default: st_reg <= CBAP_HOST_IDLE;
			endcase
		end
	end

	assign bus.bus_cycle_done_n = done_n_reg;

	always_ff @(posedge I_CORE_CLK or negedge I_RESET_N)
	begin
		if (!I_RESET_N)
		begin
			seen_reg <= 1'b0;
			seen_addr_reg <= `CBAP_RST_ADDR;
			seen_be_reg <= '1;
			seen_perr_reg <= 1'b0;
			inq_err_reg <= 1'b0;
		end
		else if (I_CLK_EN)
		begin
			seen_reg <= strobe;
			seen_perr_reg <= strobe &
				(^{bus.addr, bus.addr_even_parity});
			inq_err_reg <= ~bus.addr_parity_error_n;
			if (strobe)
			begin
				seen_addr_reg <= bus.addr;
				seen_be_reg <= bus.byte_lane_enable_n;
			end
		end
	end

	assign O_INQ_READY = inq_ready_reg;
	assign O_CYCLE_SEEN = seen_reg;
	assign O_CYCLE_ADDR = seen_addr_reg;
	assign O_CYCLE_BE_N = seen_be_reg;
	assign O_CYCLE_PERR = seen_perr_reg;
	assign O_INQ_ERR = inq_err_reg;

endmodule
`default_nettype wire

// File: tb/cbap_bus_sva.sv
`timescale 1ns/1ps
`default_nettype none

// ****
// wire checks between the two ends
// ****
module cbap_bus_sva
	import cbap_pkg::*;
(
	input wire logic I_CORE_CLK,
	input wire logic I_RESET_N,
	input wire cbap_addr_type addr,
	input wire logic addr_even_parity,
	input wire logic cycle_addr_strobe_n,
	input wire logic dev_addr_oe,
	input wire logic dev_ap_oe,
	input wire logic be_oe,
	input wire logic ads_oe,
	input wire logic addr_parity_error_n,
	input wire logic addr_bit20_mask_n,
	input wire logic addr_float_request,
	input wire logic bus_abort_retry_n,
	input wire logic inquire_addr_strobe_n
);
	default clocking cb @(posedge I_CORE_CLK);
	endclocking
	default disable iff (!I_RESET_N);

	sequence s_inq_bad;
		!inquire_addr_strobe_n && (^{addr, addr_even_parity});
	endsequence
	sequence s_inq_good;
		!inquire_addr_strobe_n && !(^{addr, addr_even_parity});
	endsequence
	sequence s_perr_pulse;
		##3 !addr_parity_error_n ##1 addr_parity_error_n;
	endsequence

	property p_strobe_parity;
		!cycle_addr_strobe_n |-> !(^{addr, addr_even_parity});
	endproperty
	a_strobe_parity: assert property (p_strobe_parity)
		else $error("odd address parity with strobe");

	// mask is judged at the edge that took the request
	property p_strobe_a20;
		(!cycle_addr_strobe_n && !addr_bit20_mask_n
			&& !$past(addr_bit20_mask_n) && !$past(addr_bit20_mask_n, 2))
			|-> !addr[20];
	endproperty
	a_strobe_a20: assert property (p_strobe_a20)
		else $error("bit 20 not masked");

	property p_strobe_be;
		!cycle_addr_strobe_n |-> be_oe && dev_addr_oe && dev_ap_oe;
	endproperty
	a_strobe_be: assert property (p_strobe_be)
		else $error("byte lanes not driven with address");

	property p_strobe_one;
		$fell(cycle_addr_strobe_n) |=> cycle_addr_strobe_n;
	endproperty
	a_strobe_one: assert property (p_strobe_one)
		else $error("strobe longer than one clock");

	property p_hold_float;
		$rose(addr_float_request) |=> !dev_addr_oe && !dev_ap_oe;
	endproperty
	a_hold_float: assert property (p_hold_float)
		else $error("address not floated after hold");

	property p_hold_others;
		(addr_float_request && $past(addr_float_request)
			&& bus_abort_retry_n && $past(bus_abort_retry_n))
			|-> be_oe && ads_oe && !dev_addr_oe;
	endproperty
	a_hold_others: assert property (p_hold_others)
		else $error("hold floated the wrong pins");

	property p_bus_abort_retry_n_float;
		$fell(bus_abort_retry_n) |=> !be_oe && !ads_oe && !dev_addr_oe;
	endproperty
	a_bus_abort_retry_n_float: assert property (p_bus_abort_retry_n_float)
		else $error("pins not floated after backoff");

	property p_bus_abort_retry_n_hold;
		!bus_abort_retry_n && !$past(bus_abort_retry_n)
			|-> cycle_addr_strobe_n && !be_oe;
	endproperty
	a_bus_abort_retry_n_hold: assert property (p_bus_abort_retry_n_hold)
		else $error("bus left hold during backoff");

	property p_perr_bad;
		s_inq_bad |-> s_perr_pulse;
	endproperty
	a_perr_bad: assert property (p_perr_bad)
		else $error("parity error pulse wrong");

	property p_perr_good;
		s_inq_good |-> ##3 addr_parity_error_n;
	endproperty
	a_perr_good: assert property (p_perr_good)
		else $error("parity error on good inquire");
endmodule
`default_nettype wire

// File: tb/tb_cpu_bus_address_phase_pins.sv
`timescale 1ns/1ps
`default_nettype none
`include "cbap_map.svh"

module tb_cpu_bus_address_phase_pins;
	import cbap_pkg::*;
	// nonzero strap so a stuck decode shows
	localparam cbap_ratio_type STRAP = 3'h5;
	logic core_clk, reset_n, req_valid, req_ready, cycle_done;
	logic inq_valid, inq_perr, ratio_valid, a20_mask, addr_hold;
	logic backoff, inq_req, inq_bad, inq_ready, cycle_seen, cycle_perr;
	logic inq_err, clk_en;
	cbap_addr_type req_addr, cyc_addr, seen_addr;
	cbap_be_type req_be, cyc_be, seen_be;
	cbap_ratio_type ratio_sel;
	logic [`CBAP_MULT_W-1:0] core_mult;
	logic [`CBAP_ADDR_HI:`CBAP_INQ_LO] dev_inq, host_inq, seen_inq;
	int fail_count, n_compared, cycles, i, k, s, d, v, r, pe;
	int ev_cnt[6];

	cbap_bus_if i_cbap_bus_if();
	cbap_dev #(.PERR_DELAY(2)) i_cbap_dev (.I_CORE_CLK(core_clk),
		.I_RESET_N(reset_n), .I_CLK_EN(clk_en), .bus(i_cbap_bus_if.dev),
		.I_REQ_VALID(req_valid), .I_REQ_ADDR(req_addr),
		.I_REQ_BYTE_EN(req_be), .O_REQ_READY(req_ready),
		.O_CYCLE_DONE(cycle_done), .O_INQ_VALID(inq_valid),
		.O_INQ_ADDR(dev_inq), .O_INQ_PERR(inq_perr),
		.O_RATIO_VALID(ratio_valid), .O_RATIO_SEL(ratio_sel),
		.O_CORE_MULT(core_mult));
	cbap_host #(.WAIT_CYC(2), .RATIO_STRAP(STRAP)) i_cbap_host (
		.I_CORE_CLK(core_clk), .I_RESET_N(reset_n), .I_CLK_EN(clk_en),
		.bus(i_cbap_bus_if.host), .I_A20_MASK(a20_mask),
		.I_ADDR_HOLD(addr_hold), .I_BACKOFF(backoff), .I_INQ_REQ(inq_req),
		.I_INQ_ADDR(host_inq), .I_INQ_BAD_PARITY(inq_bad),
		.O_INQ_READY(inq_ready), .O_CYCLE_SEEN(cycle_seen),
		.O_CYCLE_ADDR(cyc_addr), .O_CYCLE_BE_N(cyc_be),
		.O_CYCLE_PERR(cycle_perr), .O_INQ_ERR(inq_err));
	cbap_bus_sva i_cbap_bus_sva (.I_CORE_CLK(core_clk), .I_RESET_N(reset_n),
		.addr(i_cbap_bus_if.addr),
		.addr_even_parity(i_cbap_bus_if.addr_even_parity),
		.cycle_addr_strobe_n(i_cbap_bus_if.cycle_addr_strobe_n),
		.dev_addr_oe(i_cbap_bus_if.dev_addr_oe),
		.dev_ap_oe(i_cbap_bus_if.dev_ap_oe), .be_oe(i_cbap_bus_if.be_oe),
		.ads_oe(i_cbap_bus_if.ads_oe),
		.addr_parity_error_n(i_cbap_bus_if.addr_parity_error_n),
		.addr_bit20_mask_n(i_cbap_bus_if.addr_bit20_mask_n),
		.addr_float_request(i_cbap_bus_if.addr_float_request),
		.bus_abort_retry_n(i_cbap_bus_if.bus_abort_retry_n),
		.inquire_addr_strobe_n(i_cbap_bus_if.inquire_addr_strobe_n));

	// ****
	// clock, watchdog and pulse counters
	// ****
	initial
	begin
		core_clk = 1'b0;
		forever #20 core_clk = ~core_clk;
	end
	always @(posedge core_clk)
	begin
		cycles++;
		if (cycles == 3000)
		begin
			fail_count++;
			finish_test();
		end
	end
	// pulses last one clock, so one falling edge sees each once
	always @(negedge core_clk)
	begin
		if (cycle_seen === 1'b1)
		begin
			ev_cnt[0]++;
			seen_addr = cyc_addr;
			seen_be = cyc_be;
		end
		if (cycle_done === 1'b1)
			ev_cnt[1]++;
		if (inq_valid === 1'b1)
		begin
			ev_cnt[2]++;
			seen_inq = dev_inq;
			if (inq_perr === 1'b1)
				ev_cnt[5]++;
		end
		if (inq_err === 1'b1)
			ev_cnt[3]++;
		if (cycle_perr === 1'b1)
			ev_cnt[4]++;
	end

	// ****
	// tasks
	// ****
	task chk(input string what, input logic [31:0] exp, got);
		n_compared++;
		if (got !== exp)
		begin
			$display("ERROR %s expected %h seen %h", what, exp, got);
			fail_count++;
		end
	endtask
	task wait_ev(input int w, input int base);
		for (int n = 0; n < 80 && ev_cnt[w] <= base; n++)
			@(negedge core_clk);
		chk("event arrival", 32'h1, 32'(ev_cnt[w] > base));
	endtask
	task dev_req(input cbap_addr_type a, input cbap_be_type be);
		@(negedge core_clk);
		for (int n = 0; n < 40 && req_ready !== 1'b1; n++)
			@(negedge core_clk);
		req_valid = 1'b1;
		req_addr = a;
		req_be = be;
		@(negedge core_clk);
		req_valid = 1'b0;
	endtask
	task run_cycle(input logic m, input cbap_addr_type a, cbap_be_type be);
		cbap_addr_type e;
		s = ev_cnt[0];
		d = ev_cnt[1];
		e = a;
		if (m)
			e[20] = 1'b0;
		a20_mask = m;
		repeat (3) @(negedge core_clk);
		dev_req(a, be);
		wait_ev(1, d);
		repeat (2) @(negedge core_clk);
		chk("cycle address", 32'(e), 32'(seen_addr));
		chk("byte lanes", {24'h0, ~be}, 32'(seen_be));
		chk("strobe count", 32'(s + 1), 32'(ev_cnt[0]));
		chk("device parity", 32'h0, 32'(ev_cnt[4]));
	endtask
	task finish_test;
		$display("compared %0d mismatches %0d", n_compared, fail_count);
		if (fail_count == 0 && n_compared > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	// ****
	// main sequence
	// ****
	initial
	begin
		{reset_n, req_valid, a20_mask, addr_hold, backoff} = 5'h00;
		{inq_req, inq_bad} = 2'h0;
		clk_en = 1'b1;
		req_addr = '0;
		req_be = '0;
		host_inq = '0;
		repeat (8) @(negedge core_clk);
		chk("ready in reset", 32'h0, 32'(req_ready));
		reset_n = 1'b1;
		repeat (2) @(negedge core_clk);
		chk("ratio valid", 32'h1, 32'(ratio_valid));
		chk("ratio sel", 32'(STRAP), 32'(ratio_sel));
		chk("multiplier", 32'h7, 32'(core_mult));
		run_cycle(1'b0, 29'h1fff_fff8, 8'ha5);
		run_cycle(1'b1, 29'h1fff_fff8, 8'h3c);
		run_cycle(1'b1, 29'h0012_3456, 8'hff);
		a20_mask = 1'b0;
		s = ev_cnt[0];
		d = ev_cnt[1];
		fork
			dev_req(29'h0246_8ac0, 8'h0f);
			begin
				repeat (2) @(negedge core_clk);
				backoff = 1'b1;
				repeat (4) @(negedge core_clk);
				backoff = 1'b0;
			end
		join
		wait_ev(1, d);
		repeat (2) @(negedge core_clk);
		chk("reissued strobes", 32'(s + 2), 32'(ev_cnt[0]));
		chk("done count", 32'(d + 1), 32'(ev_cnt[1]));
		chk("reissued address", 32'h0246_8ac0, 32'(seen_addr));
		addr_hold = 1'b1;
		for (i = 0; i < 2; i++)
		begin
			v = ev_cnt[2];
			r = ev_cnt[3];
			pe = ev_cnt[5];
			for (k = 0; k < 40 && inq_ready !== 1'b1; k++)
				@(negedge core_clk);
			host_inq = i ? 27'h5a5_a5a5 : 27'h123_4567;
			inq_bad = i[0];
			inq_req = 1'b1;
			@(negedge core_clk);
			inq_req = 1'b0;
			wait_ev(2, v);
			repeat (6) @(negedge core_clk);
			chk("inquire address", 32'(host_inq), 32'(seen_inq));
			chk("parity flag", 32'(i), 32'(ev_cnt[5] - pe));
			chk("parity pin", 32'(r + i), 32'(ev_cnt[3]));
		end
		addr_hold = 1'b0;
		inq_bad = 1'b0;
		repeat (3) @(negedge core_clk);
		reset_n = 1'b0;
		repeat (2) @(negedge core_clk);
		chk("ratio valid in reset", 32'h0, 32'(ratio_valid));
		clk_en = 1'b0;
		reset_n = 1'b1;
		repeat (2) @(negedge core_clk);
		chk("ratio held while frozen", 32'h0, 32'(ratio_valid));
		chk("ready held while frozen", 32'h0, 32'(req_ready));
		clk_en = 1'b1;
		repeat (2) @(negedge core_clk);
		chk("ratio recaptured", 32'(STRAP), 32'(ratio_sel));
		finish_test();
	end
endmodule
`default_nettype wire
